// >>> verilog/slpm_pkg.sv
// Purpose: constants for the serial lane port mapping block
// Assumes: four lane macros, four lanes each
// Notes:   port numbering base n, n+1, n+8, n+9
`default_nettype none
package slpm_pkg;
   localparam int unsigned NUM_MACROS      = 4;
   localparam int unsigned LANES_PER_MACRO = 4;
   localparam int unsigned NUM_PORTS       = 16;
   localparam int unsigned PORT_IDX_W      = 4;
   // strap hold window after reset, in core clock cycles
   localparam int unsigned STRAP_HOLD_CYC  = 20;
   localparam int unsigned STRAP_CNT_W     = 5;
   // lane offsets from the macro base port in single-lane mode
   localparam logic [3:0]  LANE_B_OFS      = 4'h1;
   localparam logic [3:0]  LANE_C_OFS      = 4'h8;
   localparam logic [3:0]  LANE_D_OFS      = 4'h9;
   // width strap encoding
   localparam logic        WIDTH_FOUR_LANE = 1'b0;
   localparam logic        WIDTH_ONE_LANE  = 1'b1;
   localparam logic        REFCLK_RST      = 1'b0;
   localparam logic [3:0]  WIDTH_RST       = 4'h0;

   typedef enum logic [1:0] {
      SLPM_ST_RESET  = 2'b00,
      SLPM_ST_SAMPLE = 2'b01,
      SLPM_ST_RUN    = 2'b10
   } slpm_state_e;

   // base port of macro m is 2*m: 0, 2, 4, 6
   function automatic logic [3:0] slpm_base(input int unsigned m);
      slpm_base = 4'((m * 2) & 32'h0000_000F);
   endfunction : slpm_base
endpackage : slpm_pkg
`default_nettype wire

// >>> verilog/slpm_lane_map.sv
// Purpose: map the lanes of four lane macros onto switch ports, latch power-up straps
// Assumes: one core clock; lane data is parallel words on both sides; straps synchronous
// Notes:   a self-reset pulse restarts the strap window like a hard reset
// How it works
// - straps held 20 cycles after reset or self-reset; sampled only in that window
// - straps ignored after window; software overrides all but reference clock select
// - four-lane mode: all four transmit lanes carry one even base port
// - four-lane mode: only receive lane A goes to base port; single-lane: all four lanes
// - single-lane mode: lanes B, C, D are ports base+1, base+8, base+9
// - width strap low means four-lane, high means single-lane; register overrides
`timescale 1ns/1ps
`default_nettype none
module slpm_lane_map
   import slpm_pkg::*;
#(
   parameter int unsigned DATA_W = 10
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          self_reset_i,
   input  wire logic [NUM_MACROS-1:0]         port_width_strap_i,
   input  wire logic                          reference_clock_strap_i,
   input  wire logic [NUM_MACROS-1:0]         macro_width_override_i,
   input  wire logic [NUM_MACROS-1:0]         macro_width_override_we_i,
   input  wire logic [NUM_PORTS*DATA_W-1:0]   port_tx_data_i,
   input  wire logic [NUM_MACROS*LANES_PER_MACRO*DATA_W-1:0] lane_rx_data_i,
   output var  logic [NUM_MACROS*LANES_PER_MACRO*DATA_W-1:0] lane_tx_data_o,
   output var  logic [NUM_PORTS*DATA_W-1:0]   port_rx_data_o,
   output var  logic [NUM_PORTS-1:0]          port_rx_lanes4_o,
   output var  logic [NUM_MACROS-1:0]         macro_one_lane_o,
   output var  logic                          reference_clock_sel_o,
   output var  logic                          straps_latched_o
);
   localparam int unsigned LD = LANES_PER_MACRO * DATA_W;

   slpm_state_e              state_q, state_d;
   logic [STRAP_CNT_W-1:0]   cnt_q;
   logic [NUM_MACROS-1:0]    width_q;
   logic                     refclk_q;

   wire  window_w   = (state_q == SLPM_ST_SAMPLE);
   wire  last_w     = window_w && (cnt_q == STRAP_CNT_W'(STRAP_HOLD_CYC - 1));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SLPM_ST_RESET:  state_d = SLPM_ST_SAMPLE;
         SLPM_ST_SAMPLE: if (last_w) state_d = SLPM_ST_RUN;
         SLPM_ST_RUN:    state_d = SLPM_ST_RUN;
         default:        state_d = SLPM_ST_RESET;
      endcase
      if (self_reset_i) state_d = SLPM_ST_RESET;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= SLPM_ST_RESET;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= window_w ? cnt_q + 1'b1 : '0;
      end
   end

   // straps tracked through the window; last cycle's value is the one kept
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         width_q  <= WIDTH_RST;
         refclk_q <= REFCLK_RST;
      end else if (window_w && !self_reset_i) begin
         width_q  <= port_width_strap_i;
         refclk_q <= reference_clock_strap_i;
      end else if (state_q == SLPM_ST_RUN) begin
         // bitwise override; reference clock select is never writable
         width_q <= (width_q & ~macro_width_override_we_i)
                  | (macro_width_override_i & macro_width_override_we_i);
      end
   end

   // per-port and per-lane routing, registered so every output comes from a flop
   logic [NUM_MACROS*LD-1:0]        tx_d;
   logic [NUM_PORTS*DATA_W-1:0]     rx_d;
   logic [NUM_PORTS-1:0]            l4_d;

   always_comb begin
      logic [3:0] b;
      b    = '0;
      tx_d = '0;
      rx_d = '0;
      l4_d = '0;
      for (int m = 0; m < NUM_MACROS; m++) begin
         b = slpm_base(m);
         if (width_q[m] == WIDTH_FOUR_LANE) begin
            for (int l = 0; l < LANES_PER_MACRO; l++) begin
               tx_d[m*LD+l*DATA_W +: DATA_W] = port_tx_data_i[b*DATA_W +: DATA_W];
            end
            rx_d[b*DATA_W +: DATA_W] = lane_rx_data_i[m*LD +: DATA_W];
            l4_d[b] = 1'b1;
         end else begin
            tx_d[m*LD +: DATA_W] = port_tx_data_i[b*DATA_W +: DATA_W];
            tx_d[m*LD+DATA_W +: DATA_W] =
               port_tx_data_i[(b+LANE_B_OFS)*DATA_W +: DATA_W];
            tx_d[m*LD+2*DATA_W +: DATA_W] =
               port_tx_data_i[(b+LANE_C_OFS)*DATA_W +: DATA_W];
            tx_d[m*LD+3*DATA_W +: DATA_W] =
               port_tx_data_i[(b+LANE_D_OFS)*DATA_W +: DATA_W];
            rx_d[b*DATA_W +: DATA_W] = lane_rx_data_i[m*LD +: DATA_W];
            rx_d[(b+LANE_B_OFS)*DATA_W +: DATA_W] =
               lane_rx_data_i[m*LD+DATA_W +: DATA_W];
            rx_d[(b+LANE_C_OFS)*DATA_W +: DATA_W] =
               lane_rx_data_i[m*LD+2*DATA_W +: DATA_W];
            rx_d[(b+LANE_D_OFS)*DATA_W +: DATA_W] =
               lane_rx_data_i[m*LD+3*DATA_W +: DATA_W];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lane_tx_data_o        <= '0;
         port_rx_data_o        <= '0;
         port_rx_lanes4_o      <= '0;
         macro_one_lane_o      <= WIDTH_RST;
         reference_clock_sel_o <= REFCLK_RST;
         straps_latched_o      <= 1'b0;
      end else begin
         lane_tx_data_o        <= tx_d;
         port_rx_data_o        <= rx_d;
         port_rx_lanes4_o      <= l4_d;
         macro_one_lane_o      <= width_q;
         reference_clock_sel_o <= refclk_q;
         straps_latched_o      <= (state_q == SLPM_ST_RUN);
      end
   end

   // separate count of window cycles, so the end test on cnt_q is checked
   logic [STRAP_CNT_W-1:0]   win_len_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         win_len_q <= '0;
      end else begin
         win_len_q <= window_w ? win_len_q + 1'b1 : '0;
      end
   end

   // assertions; a self-reset inside the window restarts it and is left out
   AST_WINDOW_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(window_w) && $past(rst_n_i) && !$past(self_reset_i)
      |-> win_len_q == STRAP_CNT_W'(STRAP_HOLD_CYC))
      else $error("strap window not 20 cycles");
   AST_WINDOW_AFTER_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      self_reset_i ##1 !self_reset_i |=> window_w)
      else $error("self-reset did not reopen strap window");
   AST_REFCLK_FIXED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) && !self_reset_i |=> $stable(refclk_q))
      else $error("reference clock select changed after window");
   AST_STRAP_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) && (macro_width_override_we_i == '0) |=> $stable(width_q))
      else $error("width changed without override");
   AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) && macro_width_override_we_i[0]
      |=> width_q[0] == $past(macro_width_override_i[0]))
      else $error("override not taken");
   AST_STRAP_TAKEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      last_w && !self_reset_i |=> width_q == $past(port_width_strap_i))
      else $error("width strap not latched");
   AST_TX4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[1] == WIDTH_FOUR_LANE
      |=> lane_tx_data_o[LD+3*DATA_W +: DATA_W] == $past(port_tx_data_i[2*DATA_W +: DATA_W]))
      else $error("four-lane transmit lane D not from base port");
   AST_RX4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[0] == WIDTH_FOUR_LANE
      |=> port_rx_lanes4_o[0] && port_rx_data_o[DATA_W +: DATA_W] == '0)
      else $error("four-lane receive mapping wrong");
   AST_RX1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[0] == WIDTH_ONE_LANE
      |=> port_rx_data_o[9*DATA_W +: DATA_W] == $past(lane_rx_data_i[3*DATA_W +: DATA_W]))
      else $error("single-lane lane D not on port base+9");
   AST_TX1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[0] == WIDTH_ONE_LANE
      |=> lane_tx_data_o[2*DATA_W +: DATA_W] == $past(port_tx_data_i[8*DATA_W +: DATA_W]))
      else $error("single-lane lane C not from port base+8");
   AST_REFCLK_TAKEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      last_w && !self_reset_i |=> refclk_q == $past(reference_clock_strap_i))
      else $error("reference clock strap not latched");
   AST_STRAP_WINDOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      window_w && !self_reset_i |=> width_q == $past(port_width_strap_i))
      else $error("width not following straps inside window");
   AST_TX1_B: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[3] == WIDTH_ONE_LANE
      |=> lane_tx_data_o[3*LD+DATA_W +: DATA_W] == $past(port_tx_data_i[7*DATA_W +: DATA_W]))
      else $error("single-lane lane B not from port base+1");
   AST_RX4_A: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[2] == WIDTH_FOUR_LANE
      |=> port_rx_data_o[4*DATA_W +: DATA_W] == $past(lane_rx_data_i[2*LD +: DATA_W]))
      else $error("four-lane receive lane A not on base port");
   AST_RX1_B: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      width_q[1] == WIDTH_ONE_LANE
      |=> port_rx_data_o[3*DATA_W +: DATA_W] == $past(lane_rx_data_i[LD+DATA_W +: DATA_W]))
      else $error("single-lane lane B not on port base+1");
   AST_LATCHED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) |=> straps_latched_o)
      else $error("latched flag missing after window");
   AST_NOT_LATCHED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      window_w |=> !straps_latched_o)
      else $error("latched flag high inside window");
   AST_ONE_LANE_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) |=> macro_one_lane_o == $past(width_q))
      else $error("width output not following width register");
   AST_REFCLK_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) |=> reference_clock_sel_o == $past(refclk_q))
      else $error("reference clock output not following latch");

   COV_LATCH: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(straps_latched_o));
   COV_ONE_LANE: cover property (@(posedge clk_i) disable iff (!rst_n_i) macro_one_lane_o[2]);
   COV_OVR: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == SLPM_ST_RUN) && (macro_width_override_we_i != '0));
   COV_SELF: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      self_reset_i && (state_q == SLPM_ST_RUN));
   COV_FOUR_LANE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(macro_one_lane_o[3]));
endmodule : slpm_lane_map
`default_nettype wire

// >>> dv/slpm_strap_model.sv
// Purpose: board strap model for the lane mapper
// Assumes: straps held from each reset or self-reset end
// Notes:   after the hold time the pins show the inverse value
`timescale 1ns/1ps
`default_nettype none
module slpm_strap_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       self_reset_i,
   input  wire logic [3:0] width_i,
   input  wire logic       refclk_i,
   output var  logic [3:0] port_width_strap_o,
   output var  logic       reference_clock_strap_o
);
   int unsigned age = 0;
   always @(posedge clk_i) age <= (!rst_n_i || self_reset_i) ? 0 : age + 1;
   // inverse after hold, so a late sample shows up as a wrong width
   assign port_width_strap_o      = (age < 22) ? width_i : ~width_i;
   assign reference_clock_strap_o = (age < 22) ? refclk_i : !refclk_i;
endmodule : slpm_strap_model
`default_nettype wire

// >>> dv/slpm_lane_map_test.sv
// Purpose: self-checking bench for the lane mapper
// Assumes: registered outputs, one cycle behind inputs
// Notes:   expected words queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module slpm_lane_map_test;
   import slpm_pkg::*;
   localparam int W = 10;
   localparam logic [3:0] OFS [4] = '{4'h0, LANE_B_OFS, LANE_C_OFS, LANE_D_OFS};
   typedef struct {logic [16*W-1:0] t, r; logic [15:0] f;} slpm_exp_s;
   logic clk = 0, rst_n = 0, self_rst = 0, ref_s = 1, ref_pin, rsel, latched;
   logic [3:0] wid = 4'hA, ov = 4'h0, ov_we = 4'h0, md = 4'hA, pws, one;
   logic [16*W-1:0] ptx = '0, lrx = '0, ltx, prx;
   logic [15:0] l4;
   logic [31:0] seed = 32'h0431E514;
   int miscompares = 0, n_checks = 0;
   slpm_exp_s q[$], got;
   always #2.5 clk = ~clk;
   slpm_strap_model i_straps (.clk_i(clk), .rst_n_i(rst_n), .self_reset_i(self_rst),
      .width_i(wid), .refclk_i(ref_s), .port_width_strap_o(pws),
      .reference_clock_strap_o(ref_pin));
   slpm_lane_map #(.DATA_W(W)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .self_reset_i(self_rst),
      .port_width_strap_i(pws), .reference_clock_strap_i(ref_pin),
      .macro_width_override_i(ov), .macro_width_override_we_i(ov_we),
      .port_tx_data_i(ptx), .lane_rx_data_i(lrx), .lane_tx_data_o(ltx),
      .port_rx_data_o(prx), .port_rx_lanes4_o(l4), .macro_one_lane_o(one),
      .reference_clock_sel_o(rsel), .straps_latched_o(latched));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic check(input logic ok, input string what);
      n_checks++;
      if (!ok) begin
         miscompares++;
         $display("Error at %0t: %s mismatch", $time, what);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic traffic(input int n);
      slpm_exp_s e;
      logic [3:0] b, o;
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         #1;
         for (int j = 0; j < 16; j++) begin
            seed = lfsr(seed);
            ptx[j*W +: W] = seed[W-1:0];
            lrx[j*W +: W] = seed[31 -: W];
         end
         e.r = '0;
         e.f = '0;
         for (int m = 0; m < 4; m++) begin
            b = 4'(2 * m);
            e.f[b] = !md[m];
            if (!md[m]) e.r[b*W +: W] = lrx[4*m*W +: W];
            for (int l = 0; l < 4; l++) begin
               o = md[m] ? b + OFS[l] : b;
               e.t[(4*m+l)*W +: W] = ptx[o*W +: W];
               if (md[m]) e.r[o*W +: W] = lrx[(4*m+l)*W +: W];
            end
         end
         q.push_back(e);
      end
   endtask : traffic
   // pops at the edge, before the driver's next push
   always @(posedge clk) begin
      if (q.size() > 0) begin
         got = q.pop_front();
         #2;
         check(ltx === got.t, "lane tx");
         check(prx === got.r, "port rx");
         check(l4 === got.f, "rx width flag");
      end
   end
   initial begin
      #5000;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (latched === 1'b1) break;
      end
      check(latched === 1'b1, "latch");
      check(one === 4'hA, "strap width");
      check(rsel === 1'b1, "strap refclk");
      traffic(40);
      repeat (2) @(posedge clk);
      #1 ov = 4'h5;
      ov_we = 4'hF;
      md = 4'h5;
      @(posedge clk);
      #1 ov_we = 4'h0;
      repeat (2) @(posedge clk);
      #1 check(one === 4'h5, "override");
      check(rsel === 1'b1, "refclk kept");
      traffic(40);
      repeat (2) @(posedge clk);
      #1 wid = 4'h3;
      ref_s = 0;
      md = 4'h3;
      self_rst = 1;
      @(posedge clk);
      #1 self_rst = 0;
      repeat (30) @(posedge clk);
      #1 check(one === 4'h3, "resampled width");
      check(rsel === 1'b0, "resampled refclk");
      traffic(40);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule : slpm_lane_map_test
`default_nettype wire
